// [design/pcd_defs.vh]
// Register map, field positions and reset values of the pin change detector
`ifndef PCD_DEFS_VH
`define PCD_DEFS_VH
// Printed offsets are not all multiples of four: each is a register index, byte address = 4 * index
`define PCD_IDX_FLAG_B     12'hE93
`define PCD_IDX_FALL_B     12'hE94
`define PCD_IDX_RISE_B     12'hE95
`define PCD_IDX_FLAG_C     12'hE9B
`define PCD_IDX_FALL_C     12'hE9C
`define PCD_IDX_RISE_C     12'hE9D
`define PCD_IDX_FLAG_E     12'hEA8
`define PCD_IDX_FALL_E     12'hEA9
`define PCD_IDX_RISE_E     12'hEAA
`define PCD_IDX_FLAG_G     12'hEB5
`define PCD_IDX_FALL_G     12'hEB6
`define PCD_IDX_RISE_G     12'hEB7
`define PCD_IDX_CTRL       12'hEC0
`define PCD_IDX_IRQ_STAT   12'hEC1
`define PCD_IDX_IRQ_MASK   12'hEC2
// Control register fields
`define PCD_CTRL_GIE_BIT   0
`define PCD_CTRL_SUM_BIT   1
`define PCD_CTRL_MCLR_BIT  2
`define PCD_CTRL_LVP_BIT   3
`define PCD_CTRL_SLEEP_BIT 4
// Interrupt status fields: one per bank
`define PCD_IRQ_B_BIT      0
`define PCD_IRQ_C_BIT      1
`define PCD_IRQ_E_BIT      2
`define PCD_IRQ_G_BIT      3
`define PCD_IRQ_W          4
// Reset values
`define PCD_RST_BYTE       8'h00
`define PCD_RST_IRQ        4'h0
// Only pin 5 of bank G is eligible
`define PCD_G_PIN_MASK     8'h20
`endif

// [design/pcd_edge_detect.v]
// Synchroniser and armed edge detector for one bank of pins
`timescale 1ns/100ps
`default_nettype none
module pcd_edge_detect #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input  wire             pclk,
  input  wire             presetn,
  // Pins and arming
  input  wire [WIDTH-1:0] pin_in,
  input  wire [WIDTH-1:0] rise_en,
  input  wire [WIDTH-1:0] fall_en,
  input  wire [WIDTH-1:0] pin_ok,
  // One pulse per armed edge
  output wire [WIDTH-1:0] edge_hit
);
  reg [WIDTH-1:0] sync1_r;
  reg [WIDTH-1:0] sync2_r;
  reg [WIDTH-1:0] prev_r;
  reg [1:0]       primed_r;

  // Two stages before any logic; primed waits two clocks, until sync2 holds a real pin sample,
  // while prev is still zero, so an armed pin that idles high gives one rising edge after reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r  <= {WIDTH{1'b0}};
      sync2_r  <= {WIDTH{1'b0}};
      prev_r   <= {WIDTH{1'b0}};
      primed_r <= 2'b00;
    end else begin
      sync1_r  <= pin_in;
      sync2_r  <= sync1_r;
      prev_r   <= sync2_r;
      primed_r <= {primed_r[0], 1'b1};
    end
  end

  // Rise and fall detectors are independent; both may be armed at once
  assign edge_hit = {WIDTH{primed_r[1]}} & pin_ok &
                    ((sync2_r & ~prev_r & rise_en) |
                     (~sync2_r & prev_r & fall_en));
endmodule // pcd_edge_detect
`default_nettype wire

// [design/pcd_top.v]
// Pin change detector with APB register access
// Operation
// - Change detection on all pins of banks B, C, E and bank G pin 5 only.
// - Any pin or combination of pins may raise the change interrupt on an edge.
// - With the global enable clear, flags still set and no change request is made; irq still follows the masked status.
// - Each pin has independent rising and falling edge detectors.
// - A set rise-enable bit arms rising detection; clear disables it.
// - A set fall-enable bit arms falling detection; clear disables it.
// - Both enable bits set detects edges in both directions together.
// - An armed edge sets the pin flag and requests interrupt if globally enabled.
// - Summary flag is set whenever any pin flag in any bank is set.
// - Writing zero clears a pin flag; writing one does not set it.
// - An edge arriving during a clearing write leaves the flag set.
// - An armed edge wakes the device from sleep when globally enabled.
// - Edges seen in sleep are in the flag registers before wake completes.
// - Bank B flag register is 8 bits at 0xE93, bit per pin, reset zero.
// - With master clear or low-voltage programming on, bank G pin 5 is not detected.
`timescale 1ns/100ps
`default_nettype none
`include "pcd_defs.vh"
module pcd_top #(
  parameter BANK_W = 8
) (
  // Clock and reset
  input  wire              pclk,
  input  wire              presetn,
  // APB slave
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [15:0]       paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output reg               pready,
  output reg               pslverr,
  // Port pins
  input  wire [BANK_W-1:0] port_bank_b,
  input  wire [BANK_W-1:0] port_bank_c,
  input  wire [BANK_W-1:0] port_bank_e,
  input  wire [BANK_W-1:0] port_bank_g,
  // Processor side
  output reg               change_irq_request,
  output reg               wake_request,
  output reg               irq
);
  reg  [BANK_W-1:0]      flag_b_r, flag_c_r, flag_e_r, flag_g_r;
  reg  [BANK_W-1:0]      fall_b_r, fall_c_r, fall_e_r, fall_g_r;
  reg  [BANK_W-1:0]      rise_b_r, rise_c_r, rise_e_r, rise_g_r;
  reg                    gie_r;
  reg                    mclr_en_r;
  reg                    lvp_en_r;
  reg                    sleep_r;
  reg  [`PCD_IRQ_W-1:0]  irq_stat_r;
  reg  [`PCD_IRQ_W-1:0]  irq_mask_r;
  reg  [31:0]            rdata_nxt;
  reg                    known_nxt;
  wire [BANK_W-1:0]      hit_b, hit_c, hit_e, hit_g;
  wire [BANK_W-1:0]      all_ok;
  wire [BANK_W-1:0]      g_ok;
  wire [`PCD_IRQ_W-1:0]  bank_evt;
  wire                   any_hit;
  wire                   summary;
  wire                   wr_en;
  wire                   rd_en;
  wire [11:0]            idx;

  // Bank G keeps only pin 5, and loses it to master clear or LOW_VOLTAGE_PROGRAM_ENABLE
  assign all_ok = {BANK_W{1'b1}};
  assign g_ok   = (mclr_en_r | lvp_en_r) ? {BANK_W{1'b0}} : `PCD_G_PIN_MASK;

  pcd_edge_detect #(.WIDTH(BANK_W)) u_det_b (
    .pclk(pclk), .presetn(presetn), .pin_in(port_bank_b), .rise_en(rise_b_r),
    .fall_en(fall_b_r), .pin_ok(all_ok), .edge_hit(hit_b));
  pcd_edge_detect #(.WIDTH(BANK_W)) u_det_c (
    .pclk(pclk), .presetn(presetn), .pin_in(port_bank_c), .rise_en(rise_c_r),
    .fall_en(fall_c_r), .pin_ok(all_ok), .edge_hit(hit_c));
  pcd_edge_detect #(.WIDTH(BANK_W)) u_det_e (
    .pclk(pclk), .presetn(presetn), .pin_in(port_bank_e), .rise_en(rise_e_r),
    .fall_en(fall_e_r), .pin_ok(all_ok), .edge_hit(hit_e));
  pcd_edge_detect #(.WIDTH(BANK_W)) u_det_g (
    .pclk(pclk), .presetn(presetn), .pin_in(port_bank_g), .rise_en(rise_g_r),
    .fall_en(fall_g_r), .pin_ok(g_ok), .edge_hit(hit_g));

  // APB: zero wait state, writes take effect in the access phase
  assign idx   = paddr[13:2];
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~penable & ~pwrite;

  // Flag update: software clears with zeros, a same-cycle edge still sets
  function [BANK_W-1:0] flag_next;
    input [BANK_W-1:0] cur;
    input              hit_wr;
    input [BANK_W-1:0] wdata;
    input [BANK_W-1:0] hit;
    begin
      flag_next = (hit_wr ? (cur & wdata) : cur) | hit;
    end
  endfunction

  function is_wr;
    input [11:0] target;
    begin
      is_wr = wr_en && (idx == target) && (paddr[1:0] == 2'b00);
    end
  endfunction

  assign bank_evt = {|hit_g, |hit_e, |hit_c, |hit_b};
  assign any_hit  = |bank_evt;
  assign summary  = |flag_b_r | |flag_c_r | |flag_e_r | |(flag_g_r & `PCD_G_PIN_MASK);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_b_r   <= `PCD_RST_BYTE;
      flag_c_r   <= `PCD_RST_BYTE;
      flag_e_r   <= `PCD_RST_BYTE;
      flag_g_r   <= `PCD_RST_BYTE;
      fall_b_r   <= `PCD_RST_BYTE;
      fall_c_r   <= `PCD_RST_BYTE;
      fall_e_r   <= `PCD_RST_BYTE;
      fall_g_r   <= `PCD_RST_BYTE;
      rise_b_r   <= `PCD_RST_BYTE;
      rise_c_r   <= `PCD_RST_BYTE;
      rise_e_r   <= `PCD_RST_BYTE;
      rise_g_r   <= `PCD_RST_BYTE;
      gie_r      <= 1'b0;
      mclr_en_r  <= 1'b0;
      lvp_en_r   <= 1'b0;
      sleep_r    <= 1'b0;
      irq_stat_r <= `PCD_RST_IRQ;
      irq_mask_r <= `PCD_RST_IRQ;
    end else begin
      // Flags record edges even in sleep, so they are ready before wake
      flag_b_r <= flag_next(flag_b_r, is_wr(`PCD_IDX_FLAG_B), pwdata[7:0], hit_b);
      flag_c_r <= flag_next(flag_c_r, is_wr(`PCD_IDX_FLAG_C), pwdata[7:0], hit_c);
      flag_e_r <= flag_next(flag_e_r, is_wr(`PCD_IDX_FLAG_E), pwdata[7:0], hit_e);
      flag_g_r <= flag_next(flag_g_r, is_wr(`PCD_IDX_FLAG_G), pwdata[7:0] & `PCD_G_PIN_MASK,
                            hit_g);
      if (is_wr(`PCD_IDX_FALL_B)) fall_b_r <= pwdata[7:0];
      if (is_wr(`PCD_IDX_FALL_C)) fall_c_r <= pwdata[7:0];
      if (is_wr(`PCD_IDX_FALL_E)) fall_e_r <= pwdata[7:0];
      if (is_wr(`PCD_IDX_FALL_G)) fall_g_r <= pwdata[7:0] & `PCD_G_PIN_MASK;
      if (is_wr(`PCD_IDX_RISE_B)) rise_b_r <= pwdata[7:0];
      if (is_wr(`PCD_IDX_RISE_C)) rise_c_r <= pwdata[7:0];
      if (is_wr(`PCD_IDX_RISE_E)) rise_e_r <= pwdata[7:0];
      if (is_wr(`PCD_IDX_RISE_G)) rise_g_r <= pwdata[7:0] & `PCD_G_PIN_MASK;
      if (is_wr(`PCD_IDX_CTRL)) begin
        gie_r     <= pwdata[`PCD_CTRL_GIE_BIT];
        mclr_en_r <= pwdata[`PCD_CTRL_MCLR_BIT];
        lvp_en_r  <= pwdata[`PCD_CTRL_LVP_BIT];
      end
      // Sleep ends on the wake edge; a write in the same cycle loses to it
      if (any_hit && gie_r)
        sleep_r <= 1'b0;
      else if (is_wr(`PCD_IDX_CTRL))
        sleep_r <= pwdata[`PCD_CTRL_SLEEP_BIT];
      if (is_wr(`PCD_IDX_IRQ_MASK)) irq_mask_r <= pwdata[`PCD_IRQ_W-1:0];
      // Write one to clear; a new event in the same cycle wins
      irq_stat_r <= (is_wr(`PCD_IDX_IRQ_STAT) ? (irq_stat_r & ~pwdata[`PCD_IRQ_W-1:0])
                                               : irq_stat_r) | bank_evt;
    end
  end

  // Read mux
  always @* begin
    rdata_nxt = 32'h0000_0000;
    known_nxt = 1'b1;
    case (idx)
      `PCD_IDX_FLAG_B:   rdata_nxt[7:0] = flag_b_r;
      `PCD_IDX_FALL_B:   rdata_nxt[7:0] = fall_b_r;
      `PCD_IDX_RISE_B:   rdata_nxt[7:0] = rise_b_r;
      `PCD_IDX_FLAG_C:   rdata_nxt[7:0] = flag_c_r;
      `PCD_IDX_FALL_C:   rdata_nxt[7:0] = fall_c_r;
      `PCD_IDX_RISE_C:   rdata_nxt[7:0] = rise_c_r;
      `PCD_IDX_FLAG_E:   rdata_nxt[7:0] = flag_e_r;
      `PCD_IDX_FALL_E:   rdata_nxt[7:0] = fall_e_r;
      `PCD_IDX_RISE_E:   rdata_nxt[7:0] = rise_e_r;
      `PCD_IDX_FLAG_G:   rdata_nxt[7:0] = flag_g_r;
      `PCD_IDX_FALL_G:   rdata_nxt[7:0] = fall_g_r;
      `PCD_IDX_RISE_G:   rdata_nxt[7:0] = rise_g_r;
      `PCD_IDX_CTRL: begin
        rdata_nxt[`PCD_CTRL_GIE_BIT]   = gie_r;
        rdata_nxt[`PCD_CTRL_SUM_BIT]   = summary;
        rdata_nxt[`PCD_CTRL_MCLR_BIT]  = mclr_en_r;
        rdata_nxt[`PCD_CTRL_LVP_BIT]   = lvp_en_r;
        rdata_nxt[`PCD_CTRL_SLEEP_BIT] = sleep_r;
      end
      `PCD_IDX_IRQ_STAT: rdata_nxt[`PCD_IRQ_W-1:0] = irq_stat_r;
      `PCD_IDX_IRQ_MASK: rdata_nxt[`PCD_IRQ_W-1:0] = irq_mask_r;
      default:           known_nxt = 1'b0;
    endcase
    if (paddr[1:0] != 2'b00 || paddr[15:14] != 2'b00)
      known_nxt = 1'b0;
  end

  // Answers are registered in setup so the access phase ends at once
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata             <= 32'h0000_0000;
      pready             <= 1'b0;
      pslverr            <= 1'b0;
      change_irq_request <= 1'b0;
      wake_request       <= 1'b0;
      irq                <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~known_nxt;
      if (rd_en)
        prdata <= known_nxt ? rdata_nxt : 32'h0000_0000;
      // Request follows the summary flag only while globally enabled
      change_irq_request <= gie_r & summary;
      wake_request       <= gie_r & sleep_r & any_hit;
      irq                <= |(irq_stat_r & irq_mask_r);
    end
  end
endmodule // pcd_top
`default_nettype wire

// [sim/pcd_monitor.sv]
// Port checker for the pin change detector
`timescale 1ns/100ps
`default_nettype none
`include "pcd_defs.vh"
module pcd_monitor #(parameter BANK_W = 8) (
  // Clock and reset
  input wire logic              pclk, presetn,
  // APB
  input wire logic              psel, penable, pwrite,
  input wire logic [15:0]       paddr,
  input wire logic [31:0]       pwdata, prdata,
  input wire logic              pready, pslverr,
  // Pins and processor side
  input wire logic [BANK_W-1:0] port_bank_b, port_bank_c, port_bank_e, port_bank_g,
  input wire logic              change_irq_request, wake_request, irq
);
  logic [4*BANK_W-1:0] pins_q;
  logic [3:0]          quiet_r;
  wire  [4*BANK_W-1:0] pins = {port_bank_b, port_bank_c, port_bank_e, port_bank_g};
  wire                 wr   = psel & penable & pwrite;
  // Calm cycles: irq, change request and wake may only move a few cycles after a pin change or a write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_q  <= '0;
      quiet_r <= 4'h0;
    end else begin
      pins_q <= pins;
      if (pins != pins_q || wr) quiet_r <= 4'h0;
      else if (quiet_r != 4'hF) quiet_r <= quiet_r + 4'h1;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_zero_wait_a: assert property (psel && !penable |=> pready)
    else $error("no ready in access cycle");
  err_with_ready_a: assert property (pslverr |-> pready && psel && penable)
    else $error("error outside access");
  misalign_err_a: assert property (pready && paddr[1:0] != 2'b00 |-> pslverr)
    else $error("misaligned access accepted");
  flag_b_mapped_a: assert property (pready && paddr == {2'b00, `PCD_IDX_FLAG_B, 2'b00} |-> !pslverr)
    else $error("flag register refused");
  read_upper_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  quiet_irq_a: assert property (quiet_r >= 4'h8 |-> $stable(irq))
    else $error("irq moved while calm");
  quiet_summary_a: assert property (quiet_r >= 4'h8 |-> $stable(change_irq_request))
    else $error("request moved while calm");
  quiet_wake_a: assert property (quiet_r >= 4'h8 |-> !wake_request)
    else $error("wake without edge");
  reset_quiet_a: assert property ($rose(presetn) |-> !irq && !change_irq_request && !wake_request)
    else $error("output active after reset");
  cover property (wake_request);
  cover property (irq);
  cover property (pslverr);
endmodule // pcd_monitor
bind pcd_top pcd_monitor #(.BANK_W(BANK_W)) u_mon (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .port_bank_b, .port_bank_c, .port_bank_e,
  .port_bank_g, .change_irq_request, .wake_request, .irq);
`default_nettype wire

// [sim/pcd_pin_model.sv]
// Board pins and processor wake input around the detector
`timescale 1ns/100ps
`default_nettype none
module pcd_pin_model (
  // Clock and bench request
  input  wire logic        pclk,
  input  wire logic [31:0] level_req,
  input  wire logic        wake_request,
  // Pins and wake count
  output var  logic [31:0] pins,
  output var  logic [7:0]  wake_count
);
  initial pins = 32'h0000_0000;
  initial wake_count = 8'h00;
  // Levels move just after an edge and are held many cycles, so every level is seen
  always @(posedge pclk) pins <= level_req;
  // Counting wakes shows a single pulse per edge
  always @(posedge pclk) if (wake_request) wake_count <= wake_count + 8'h01;
endmodule // pcd_pin_model
`default_nettype wire

// [sim/tb_pin_edge_change_interrupt.sv]
// Self-checking bench for the pin change detector
`timescale 1ns/100ps
`default_nettype none
`include "pcd_defs.vh"
module tb_pin_edge_change_interrupt;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0, lvl = 32'h0, rd;
  logic [31:0] cfg [2] = '{32'h5, 32'h9};
  wire  [31:0] prdata, pins;
  wire         pready, pslverr, chg, wake, irq;
  wire  [7:0]  wakes;
  int          bad_count = 0, samples_checked = 0;
  initial forever #2.5 pclk = ~pclk;
  pcd_top #(.BANK_W(8)) uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .port_bank_b(pins[31:24]), .port_bank_c(pins[23:16]),
    .port_bank_e(pins[15:8]), .port_bank_g(pins[7:0]), .change_irq_request(chg),
    .wake_request(wake), .irq);
  pcd_pin_model pm (.pclk, .level_req(lvl), .wake_request(wake), .pins, .wake_count(wakes));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    if (n >= 50) chk(32'h0, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdchk(input logic [11:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 32'h0);
    chk(rd, exp);
  endtask
  // Each level is held well past the sync and compare delay
  task automatic drive(input logic [31:0] v);
    lvl <= v;
    repeat (8) @(posedge pclk);
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    $display("wrong value at %0t: run hung", $time);
    conclude;
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk(`PCD_IDX_FLAG_B, 32'h0);
    xfer(1'b0, 12'hE96, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    xfer(1'b1, `PCD_IDX_RISE_B, 32'h05);
    xfer(1'b1, `PCD_IDX_FALL_B, 32'h06);
    drive(32'h0F00_0000);
    rdchk(`PCD_IDX_FLAG_B, 32'h05);
    chk({31'h0, chg}, 32'h0);
    drive(32'h0000_0000);
    rdchk(`PCD_IDX_FLAG_B, 32'h07);
    rdchk(`PCD_IDX_CTRL, 32'h2);
    xfer(1'b1, `PCD_IDX_IRQ_MASK, 32'h1);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    xfer(1'b1, `PCD_IDX_CTRL, 32'h1);
    @(posedge pclk);
    chk({31'h0, chg}, 32'h1);
    xfer(1'b1, `PCD_IDX_IRQ_STAT, 32'h1);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    xfer(1'b0, `PCD_IDX_FLAG_B, 32'h0);
    xfer(1'b1, `PCD_IDX_FLAG_B, ~rd);
    rdchk(`PCD_IDX_FLAG_B, 32'h0);
    xfer(1'b1, `PCD_IDX_FLAG_C, 32'hFF);
    rdchk(`PCD_IDX_FLAG_C, 32'h0);
    xfer(1'b1, `PCD_IDX_RISE_C, 32'h1);
    lvl <= 32'h0001_0000;
    repeat (2) @(posedge pclk);
    xfer(1'b1, `PCD_IDX_FLAG_C, 32'h0);
    rdchk(`PCD_IDX_FLAG_C, 32'h1);
    xfer(1'b1, `PCD_IDX_RISE_G, 32'hFF);
    rdchk(`PCD_IDX_RISE_G, 32'h20);
    drive(32'h0001_00FF);
    rdchk(`PCD_IDX_FLAG_G, 32'h20);
    xfer(1'b1, `PCD_IDX_FLAG_G, 32'h0);
    foreach (cfg[i]) begin
      xfer(1'b1, `PCD_IDX_CTRL, cfg[i]);
      drive(32'h0001_0000);
      drive(32'h0001_00FF);
      rdchk(`PCD_IDX_FLAG_G, 32'h0);
    end
    xfer(1'b1, `PCD_IDX_RISE_E, 32'h80);
    xfer(1'b1, `PCD_IDX_CTRL, 32'h11);
    drive(32'h0001_80FF);
    chk({24'h0, wakes}, 32'h1);
    rdchk(`PCD_IDX_FLAG_E, 32'h80);
    rdchk(`PCD_IDX_CTRL, 32'h3);
    conclude;
  end
endmodule // tb_pin_edge_change_interrupt
`default_nettype wire
